/* File: pkg/crg_defines.vh */
`ifndef CRG_DEFINES_VH
`define CRG_DEFINES_VH

// ****************************************************************
// bus identity and widths
// ****************************************************************
`define CRG_DEV_CODE      6'h26
`define CRG_RECV_CODE     6'h25
`define CRG_DATA_W        16
`define CRG_ADDR_W        10
`define CRG_CNT_W         10
`define CRG_FIFO_DEPTH    4
`define CRG_FIFO_AW       2

// ****************************************************************
// control and status word layout
// ****************************************************************
`define CRG_BIT_TGT_RST   0
`define CRG_BIT_BUF_SEL   1
`define CRG_BIT_DIAG      2
`define CRG_BIT_CNT_SEL   3
`define CRG_CNT_LSB       6
`define CRG_CNT_MSB       15

// ****************************************************************
// reset values
// ****************************************************************
`define CRG_CTRL_RESET    1'b0
`define CRG_INTERROG_RST  16'h0000

`endif

/* File: tb/crg_host_port_chk.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// port checker for the host port
// ****************************************************************
module crg_host_port_chk (
   input wire logic        i_sys_clk,
   input wire logic        i_rst_n,
   input wire logic        i_read_primary_transfer,
   input wire logic        i_read_secondary_transfer,
   input wire logic        i_read_status_transfer,
   input wire logic        i_write_control_transfer,
   input wire logic        i_io_bus_reset,
   input wire logic        i_tgt_reset_done,
   input wire logic [15:0] o_bus_data,
   input wire logic        o_bus_data_oe,
   input wire logic        o_int_req,
   input wire logic        o_tgt_reset_req,
   input wire logic        o_mpu_reinit
);
   wire logic rd_any;

   // any read strobe at the pin
   assign rd_any = i_read_primary_transfer | i_read_secondary_transfer |
                   i_read_status_transfer;

   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   property p_no_irq; o_int_req == 1'b0; endproperty
   a_no_irq: assert property (p_no_irq)
      else $error("interrupt request raised");
   property p_rd_answer; $rose(rd_any) |-> ##[4:8] o_bus_data_oe; endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read not answered in time");
   property p_oe_cause; $rose(o_bus_data_oe) |-> rd_any && $past(rd_any, 2); endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("bus driven without a read");
   property p_oe_drop; $fell(rd_any) |-> ##[1:6] !o_bus_data_oe; endproperty
   a_oe_drop: assert property (p_oe_drop)
      else $error("bus still driven after read ended");
   property p_hold; o_bus_data_oe && $past(o_bus_data_oe) |-> $stable(o_bus_data); endproperty
   a_hold: assert property (p_hold)
      else $error("read data changed while driven");
   property p_reinit; $rose(i_io_bus_reset) |-> ##[2:7] o_mpu_reinit; endproperty
   a_reinit: assert property (p_reinit)
      else $error("no reinit after io reset");
   property p_reinit_one; o_mpu_reinit |=> !o_mpu_reinit; endproperty
   a_reinit_one: assert property (p_reinit_one)
      else $error("reinit longer than one cycle");
   property p_tgt_set; $rose(o_tgt_reset_req) |-> $past(i_write_control_transfer, 2); endproperty
   a_tgt_set: assert property (p_tgt_set)
      else $error("target reset set without control write");
   property p_tgt_clr; i_tgt_reset_done && o_tgt_reset_req |=> !o_tgt_reset_req; endproperty
   a_tgt_clr: assert property (p_tgt_clr)
      else $error("target reset not cleared by done");
endmodule // crg_host_port_chk

bind crg_host_port crg_host_port_chk crg_host_port_chk_i (.i_sys_clk, .i_rst_n,
   .i_read_primary_transfer, .i_read_secondary_transfer, .i_read_status_transfer,
   .i_write_control_transfer, .i_io_bus_reset, .i_tgt_reset_done, .o_bus_data,
   .o_bus_data_oe, .o_int_req, .o_tgt_reset_req, .o_mpu_reinit);
`default_nettype wire

/* File: tb/crg_mpu_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// microprocessor stand-in: finishes a target reset after a delay
// ****************************************************************
module crg_mpu_model #(
   parameter int DELAY = 40
) (
   // clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_rst_n,
   // target reset handshake
   input  wire logic i_req,
   output var  logic o_done
);
   int cnt_q;

   // slow on purpose so the set bit can be read back before it clears
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q  <= 0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_req && !o_done) begin
            cnt_q <= cnt_q + 1;
            if (cnt_q == DELAY - 1) begin
               o_done <= 1'b1;
               cnt_q  <= 0;
            end
         end else begin
            cnt_q <= 0;
         end
      end
   end
endmodule // crg_mpu_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "crg_defines.vh"

// ****************************************************************
// self-checking bench for the host port
// ****************************************************************
module testbench;
   logic        i_sys_clk;
   logic        i_rst_n;
   logic [5:0]  dev_code;
   logic [5:0]  stb;
   logic        pulse_q;
   logic        io_rst;
   logic [15:0] bus_in;
   logic [15:0] o_bus_data;
   logic        done;
   logic        tgt_req;
   logic [15:0] icnt;
   logic        int_req;
   logic        wr_rdy;
   logic [15:0] q;
   int          err_count;
   int          n_checks;

   crg_host_port crg_host_port_i (
      .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_dev_code(dev_code),
      .i_read_primary_transfer(stb[0]), .i_read_secondary_transfer(stb[1]),
      .i_read_status_transfer(stb[2]), .i_write_primary_transfer(stb[3]),
      .i_write_secondary_transfer(stb[4]), .i_write_control_transfer(stb[5]),
      .i_pulse_qual(pulse_q), .i_io_bus_reset(io_rst), .i_bus_data(bus_in),
      .o_bus_data(o_bus_data), .o_bus_data_oe(), .o_int_req(int_req), .o_wr_ready(wr_rdy),
      .o_tgt_reset_req(tgt_req), .i_tgt_reset_done(done), .o_mpu_reinit(),
      .o_interrog_cnt(icnt));

   crg_mpu_model crg_mpu_model_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .i_req(tgt_req), .o_done(done));

   // clock
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end

   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one transfer: strobe held 7 cycles, low 5, well past the sync delay
   task automatic bus(input int k, input logic [15:0] d, input logic p,
                      input logic [5:0] code, output logic [15:0] r);
      @(negedge i_sys_clk);
      dev_code = code;
      bus_in   = d;
      pulse_q  = p;
      stb[k]   = 1'b1;
      repeat (7) @(negedge i_sys_clk);
      r       = o_bus_data;
      stb[k]  = 1'b0;
      pulse_q = 1'b0;
      repeat (5) @(negedge i_sys_clk);
   endtask

   task automatic wr(input int k, input logic [15:0] d, input logic p = 1'b0);
      logic [15:0] dummy;
      bus(k, d, p, `CRG_DEV_CODE, dummy);
   endtask

   task automatic rd(input int k, input string nm, input logic [15:0] exp);
      logic [15:0] r;
      bus(k, 16'h0000, 1'b0, `CRG_DEV_CODE, r);
      chk(nm, r, exp);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // watchdog: the run needs about 30k cycles
   initial begin
      #500_000;
      err_count++;
      tally_and_finish();
   end

   // main sequence
   initial begin
      err_count = 0;
      n_checks  = 0;
      i_rst_n   = 1'b0;
      dev_code  = 6'h00;
      stb       = 6'h00;
      pulse_q   = 1'b0;
      io_rst    = 1'b0;
      bus_in    = 16'h0000;
      repeat (8) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      repeat (2) @(negedge i_sys_clk);
      chk("int_req", {15'h0000, int_req}, 16'h0000);
      chk("wr_ready", {15'h0000, wr_rdy}, 16'h0001);
      rd(2, "status_rst", 16'h0000);
      wr(5, 16'h0004);
      for (int i = 0; i < 4; i++) wr(3, 16'hA000 + i, i == 3);
      for (int i = 0; i < 10; i++) wr(4, 16'hB000 + i, i == 9);
      rd(2, "status_rc0", 16'h0044);
      wr(5, 16'h000C);
      rd(2, "status_rc1", 16'h004C);
      for (int i = 0; i < 4; i++) rd(0, "prim_rd", 16'hA000 + i);
      for (int i = 0; i < 10; i++) rd(1, "sec_rd", 16'hB000 + i);
      wr(5, 16'h0006);
      rd(2, "status_ps1", 16'h0046);
      wr(3, 16'hC0DE);
      rd(0, "ps1_prim", 16'hC0DE);
      wr(3, 16'hD00D);
      wr(5, 16'h0002);
      rd(0, "normal_rd", 16'h0000);
      wr(5, 16'h0006);
      rd(0, "diag_rd", 16'hD00D);
      bus(5, 16'h000F, 1'b0, `CRG_RECV_CODE, q);
      rd(2, "other_code", 16'h0046);
      chk("interrog", icnt, 16'hFFFF);
      wr(5, 16'h0007);
      rd(2, "tgt_set", 16'h0047);
      repeat (50) @(negedge i_sys_clk);
      rd(2, "tgt_done", 16'h0046);
      // io bus reset keeps the mode bits but clears target reset and zeroes the reply counters
      @(negedge i_sys_clk);
      io_rst = 1'b1;
      repeat (6) @(negedge i_sys_clk);
      io_rst = 1'b0;
      repeat (6) @(negedge i_sys_clk);
      rd(2, "io_bus_reset_p", 16'h0006);
      wr(5, 16'h000E);
      rd(2, "io_bus_reset_s", 16'h000E);
      // buffer 1 is primary now: only its counter moves, select is relative
      wr(3, 16'h1234, 1'b1);
      rd(2, "rc1_sec", 16'h000E);
      wr(5, 16'h0006);
      rd(2, "rc0_pri", 16'h0046);
      // fill buffer 0 past its end, then read it all around once more
      wr(5, 16'h0004);
      for (int i = 0; i < 1024; i++) wr(3, i[15:0]);
      wr(3, 16'hABCD);
      for (int i = 0; i < 1025; i++) rd(0, "wrap", (i % 1024 == 0) ? 16'hABCD : i[15:0]);
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire

/* File: verilog/crg_fifo.v */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// small synchronous fifo, valid/ready on both sides
// ****************************************************************
module crg_fifo #(
   parameter WIDTH = 18,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   // clock and reset
   input  wire             i_sys_clk,
   input  wire             i_rst_n,
   input  wire             i_flush,
   // fill side
   input  wire [WIDTH-1:0] i_in_data,
   input  wire             i_in_valid,
   output wire             o_in_ready,
   // drain side
   output wire [WIDTH-1:0] o_out_data,
   output wire             o_out_valid,
   input  wire             i_out_ready
);

   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_q;
   reg [AW-1:0]    rd_ptr_q;
   reg [AW:0]      count_q;
   wire            push;
   wire            pop;

   // full and empty come straight from the occupancy count
   assign o_in_ready  = (count_q != DEPTH[AW:0]);
   assign o_out_valid = (count_q != {(AW+1){1'b0}});
   assign o_out_data  = mem_q[rd_ptr_q];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   // storage has no reset, only the pointers and count do
   always @(posedge i_sys_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= i_in_data;
      end
   end

   // pointers and count; flush drops whatever is queued
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q  <= {(AW+1){1'b0}};
      end else if (i_flush) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (push & ~pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop & ~push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

endmodule // crg_fifo

`default_nettype wire

/* File: verilog/crg_host_port.v */
`timescale 1ns/100ps
`default_nettype none
`include "crg_defines.vh"

module crg_host_port (
   // clock and reset
   input  wire                    i_sys_clk,
   input  wire                    i_rst_n,
   // host programmed i/o bus
   input  wire [5:0]              i_dev_code,
   input  wire                    i_read_primary_transfer,
   input  wire                    i_read_secondary_transfer,
   input  wire                    i_read_status_transfer,
   input  wire                    i_write_primary_transfer,
   input  wire                    i_write_secondary_transfer,
   input  wire                    i_write_control_transfer,
   input  wire                    i_pulse_qual,
   input  wire                    i_io_bus_reset,
   input  wire [`CRG_DATA_W-1:0]  i_bus_data,
   output reg  [`CRG_DATA_W-1:0]  o_bus_data,
   output reg                     o_bus_data_oe,
   output wire                    o_int_req,
   output wire                    o_wr_ready,
   // internal microprocessor side
   output wire                    o_tgt_reset_req,
   input  wire                    i_tgt_reset_done,
   output reg                     o_mpu_reinit,
   output reg  [15:0]             o_interrog_cnt
);

   // ****************************************************************
   // pin synchroniser
   // ****************************************************************
   localparam SYNC_W = 6 + 8 + `CRG_DATA_W;

   wire [SYNC_W-1:0] pins_raw;
   reg  [SYNC_W-1:0] sync1_q;
   reg  [SYNC_W-1:0] sync2_q;
   reg  [7:0]        strb_prev_q;

   assign pins_raw = {i_dev_code, i_read_primary_transfer, i_read_secondary_transfer,
                      i_read_status_transfer, i_write_primary_transfer,
                      i_write_secondary_transfer, i_write_control_transfer,
                      i_pulse_qual, i_io_bus_reset, i_bus_data};

   // data and strobes share the two-stage delay so they stay aligned
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_q     <= {SYNC_W{1'b0}};
         sync2_q     <= {SYNC_W{1'b0}};
         strb_prev_q <= 8'h00;
      end else begin
         sync1_q     <= pins_raw;
         sync2_q     <= sync1_q;
         strb_prev_q <= sync2_q[`CRG_DATA_W +: 8];
      end
   end

   // ****************************************************************
   // strobe decode
   // ****************************************************************
   wire [5:0]             s_code;
   wire [7:0]             s_strb;
   wire [7:0]             s_rise;
   wire [`CRG_DATA_W-1:0] s_data;
   wire                   hit_dev;
   wire                   hit_recv;
   wire                   rd_pri;
   wire                   rd_sec;
   wire                   rd_stat;
   wire                   wr_pri;
   wire                   wr_sec;
   wire                   wr_ctl;
   wire                   s_pulse;
   wire                   io_reset;
   wire                   any_read_held;

   assign s_code   = sync2_q[SYNC_W-1 -: 6];
   assign s_strb   = sync2_q[`CRG_DATA_W +: 8];
   assign s_data   = sync2_q[`CRG_DATA_W-1:0];
   assign s_rise   = s_strb & ~strb_prev_q;
   assign hit_dev  = (s_code == `CRG_DEV_CODE);
   assign hit_recv = (s_code == `CRG_RECV_CODE);

   // only six transfers decode; start, clear and busy/done do not exist here
   assign rd_pri   = hit_dev & s_rise[7];
   assign rd_sec   = hit_dev & s_rise[6];
   assign rd_stat  = hit_dev & s_rise[5];
   assign wr_pri   = hit_dev & s_rise[4];
   assign wr_sec   = hit_dev & s_rise[3];
   assign wr_ctl   = hit_dev & s_rise[2];
   assign s_pulse  = s_strb[1];
   assign io_reset = s_rise[0];
   assign any_read_held = hit_dev & (|s_strb[7:5]);

   // no mask bit and no interrupt source in this interface
   assign o_int_req = 1'b0;

   // ****************************************************************
   // control and status word
   // ****************************************************************
   reg tgt_rst_q;
   reg buf_sel_q;
   reg diag_q;
   reg cnt_sel_q;

   assign o_tgt_reset_req = tgt_rst_q;

   // target reset: set by the host, cleared by the microprocessor; set wins
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tgt_rst_q <= `CRG_CTRL_RESET;
      end else if (wr_ctl & s_data[`CRG_BIT_TGT_RST]) begin
         tgt_rst_q <= 1'b1;
      end else if (io_reset | i_tgt_reset_done) begin
         tgt_rst_q <= 1'b0;
      end
   end

   // mode bits follow the status layout on a control write
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         buf_sel_q <= `CRG_CTRL_RESET;
         diag_q    <= `CRG_CTRL_RESET;
         cnt_sel_q <= `CRG_CTRL_RESET;
      end else if (wr_ctl) begin
         buf_sel_q <= s_data[`CRG_BIT_BUF_SEL];
         diag_q    <= s_data[`CRG_BIT_DIAG];
         cnt_sel_q <= s_data[`CRG_BIT_CNT_SEL];
      end
   end

   // reinit strobe to the microprocessor, one cycle per io reset
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mpu_reinit <= 1'b0;
      end else begin
         o_mpu_reinit <= io_reset;
      end
   end

   // receiver counter: a control write there moves no data at all
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_interrog_cnt <= `CRG_INTERROG_RST;
      end else if (hit_recv & s_rise[2]) begin
         o_interrog_cnt <= o_interrog_cnt - 16'h0001;
      end
   end

   // ****************************************************************
   // write path through the fifo
   // ****************************************************************
   localparam FIFO_W = 2 + `CRG_DATA_W;

   wire [FIFO_W-1:0] fifo_in;
   wire [FIFO_W-1:0] fifo_out;
   wire              fifo_in_valid;
   wire              fifo_out_valid;
   wire              fifo_out_ready;
   wire              fifo_pop;
   wire              wr_phys;

   // physical buffer is fixed when the write is accepted, not when drained
   assign wr_phys       = wr_sec ^ buf_sel_q;
   assign fifo_in_valid = wr_pri | wr_sec;
   // pulse marks the final word; the host keeps it to buffer writes
   assign fifo_in       = {wr_phys, s_pulse, s_data};
   // a buffer read owns the memories this cycle, so draining waits
   assign fifo_out_ready = ~(rd_pri | rd_sec);
   assign fifo_pop       = fifo_out_valid & fifo_out_ready;

   crg_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (`CRG_FIFO_DEPTH),
      .AW    (`CRG_FIFO_AW)
   ) u_wr_fifo (
      .i_sys_clk   (i_sys_clk),
      .i_rst_n     (i_rst_n),
      .i_flush     (io_reset),
      .i_in_data   (fifo_in),
      .i_in_valid  (fifo_in_valid),
      .o_in_ready  (o_wr_ready),
      .o_out_data  (fifo_out),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (fifo_out_ready)
   );

   // ****************************************************************
   // the two buffer memories
   // ****************************************************************
   wire                   rd_phys;
   wire                   rd_go;
   wire [`CRG_DATA_W-1:0] buf_rd_data [0:1];
   wire [`CRG_CNT_W-1:0]  buf_cnt [0:1];

   // a read in normal mode neither advances a pointer nor shows data
   assign rd_go   = (rd_pri | rd_sec) & diag_q;
   assign rd_phys = rd_sec ^ buf_sel_q;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_buf
         crg_reply_buffer u_buf (
            .i_sys_clk   (i_sys_clk),
            .i_rst_n     (i_rst_n),
            .i_clear     (io_reset),
            .i_wr_en     (fifo_pop & (fifo_out[FIFO_W-1] == gi)),
            .i_wr_data   (fifo_out[`CRG_DATA_W-1:0]),
            .i_wr_last   (fifo_out[`CRG_DATA_W]),
            .i_rd_en     (rd_go & (rd_phys == gi)),
            .o_rd_data   (buf_rd_data[gi]),
            .o_reply_cnt (buf_cnt[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // read answer
   // ****************************************************************
   localparam SRC_NONE = 2'b00;
   localparam SRC_BUF  = 2'b01;
   localparam SRC_STAT = 2'b10;
   localparam SRC_ZERO = 2'b11;

   reg [1:0]             src_q;
   reg                   src_buf_q;
   reg [`CRG_DATA_W-1:0] stat_q;
   reg [`CRG_DATA_W-1:0] ans_d;

   // status word with the counter picked by the counter-select bit
   function [`CRG_DATA_W-1:0] status_word;
      input [`CRG_CNT_W-1:0] cnt;
      input                  rc;
      input                  dg;
      input                  ps;
      input                  tr;
      begin
         status_word = {`CRG_DATA_W{1'b0}};
         status_word[`CRG_CNT_MSB:`CRG_CNT_LSB] = cnt;
         status_word[`CRG_BIT_CNT_SEL] = rc;
         status_word[`CRG_BIT_DIAG]    = dg;
         status_word[`CRG_BIT_BUF_SEL] = ps;
         status_word[`CRG_BIT_TGT_RST] = tr;
      end
   endfunction

   // remember what the answer will be built from, one cycle on
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         src_q     <= SRC_NONE;
         src_buf_q <= 1'b0;
         stat_q    <= {`CRG_DATA_W{1'b0}};
      end else begin
         src_buf_q <= rd_phys;
         // counters belong to their memory, so the pick is relative to buffer select
         stat_q    <= status_word(buf_cnt[cnt_sel_q ^ buf_sel_q],
                                  cnt_sel_q, diag_q, buf_sel_q, tgt_rst_q);
         if (rd_stat) begin
            src_q <= SRC_STAT;
         end else if (rd_go) begin
            src_q <= SRC_BUF;
         end else if (rd_pri | rd_sec) begin
            src_q <= SRC_ZERO;
         end else begin
            src_q <= SRC_NONE;
         end
      end
   end

   // answer mux, selected by the source remembered above
   always @* begin
      case (src_q)
         SRC_BUF:  ans_d = buf_rd_data[src_buf_q];
         SRC_STAT: ans_d = stat_q;
         SRC_ZERO: ans_d = {`CRG_DATA_W{1'b0}};
         default:  ans_d = o_bus_data;
      endcase
   end

   // data holds and the bus is driven until the read strobe drops
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_bus_data    <= {`CRG_DATA_W{1'b0}};
         o_bus_data_oe <= 1'b0;
      end else begin
         o_bus_data <= ans_d;
         if (src_q != SRC_NONE) begin
            o_bus_data_oe <= 1'b1;
         end else if (!any_read_held) begin
            o_bus_data_oe <= 1'b0;
         end
      end
   end

endmodule // crg_host_port

`default_nettype wire

/* File: verilog/crg_reply_buffer.v */
`timescale 1ns/100ps
`default_nettype none
`include "crg_defines.vh"

// ****************************************************************
// one buffer memory with its own pointers and reply counter
// ****************************************************************
module crg_reply_buffer (
   // clock and reset
   input  wire                    i_sys_clk,
   input  wire                    i_rst_n,
   input  wire                    i_clear,
   // write side
   input  wire                    i_wr_en,
   input  wire [`CRG_DATA_W-1:0]  i_wr_data,
   input  wire                    i_wr_last,
   // read side
   input  wire                    i_rd_en,
   output reg  [`CRG_DATA_W-1:0]  o_rd_data,
   // state
   output wire [`CRG_CNT_W-1:0]   o_reply_cnt
);

   reg [`CRG_DATA_W-1:0] mem_q [0:(1<<`CRG_ADDR_W)-1];
   reg [`CRG_ADDR_W-1:0] rd_addr_q;
   reg [`CRG_ADDR_W-1:0] wr_addr_q;
   reg [`CRG_CNT_W-1:0]  reply_cnt_q;

   assign o_reply_cnt = reply_cnt_q;

   // array port: write and read may both fire, each at its own pointer
   always @(posedge i_sys_clk) begin
      if (i_wr_en) begin
         mem_q[wr_addr_q] <= i_wr_data;
      end
      if (i_rd_en) begin
         o_rd_data <= mem_q[rd_addr_q];
      end
   end

   // pointers are ten bits wide, so 1023 + 1 rolls to zero by itself
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_addr_q   <= {`CRG_ADDR_W{1'b0}};
         wr_addr_q   <= {`CRG_ADDR_W{1'b0}};
         reply_cnt_q <= {`CRG_CNT_W{1'b0}};
      end else if (i_clear) begin
         rd_addr_q   <= {`CRG_ADDR_W{1'b0}};
         wr_addr_q   <= {`CRG_ADDR_W{1'b0}};
         reply_cnt_q <= {`CRG_CNT_W{1'b0}};
      end else begin
         if (i_rd_en) begin
            rd_addr_q <= rd_addr_q + 1'b1;
         end
         if (i_wr_en) begin
            wr_addr_q <= wr_addr_q + 1'b1;
         end
         if (i_wr_en & i_wr_last) begin
            reply_cnt_q <= reply_cnt_q + 1'b1;
         end
      end
   end

endmodule // crg_reply_buffer

`default_nettype wire
